// File: edu_pkg.sv
// Shared constants, codes and state encodings of the exception dispatch unit.
package edu_pkg;
   // Datapath widths.
   localparam int DATA_W = 64;
   localparam int FLAGS_W = 32;
   localparam int SEL_W = 16;
   localparam int FP_CONDS = 6;
   // Register map of the software port.
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_BASE = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam logic [3:0] REG_FPC = 4'hC;
   localparam logic [2:0] CTRL_RST = 3'h4;
   localparam int CTRL_EN_BIT = 2;
   // Operating modes held in the control register.
   localparam logic [1:0] MODE_REAL = 2'h0;
   localparam logic [1:0] MODE_LEGACY = 2'h1;
   localparam logic [1:0] MODE_LONG = 2'h2;
   // Request kinds issued by the pipeline.
   localparam logic [2:0] KIND_SOFT = 3'h0;
   localparam logic [2:0] KIND_OVF = 3'h1;
   localparam logic [2:0] KIND_BRK = 3'h2;
   localparam logic [2:0] KIND_LIMIT = 3'h3;
   localparam logic [2:0] KIND_FPU = 3'h4;
   localparam logic [2:0] KIND_SIMD = 3'h5;
   localparam logic [2:0] KIND_EXC = 3'h6;
   localparam logic [2:0] KIND_RET = 3'h7;
   // Fixed trap vectors.
   localparam logic [7:0] VEC_BRK = 8'h03;
   localparam logic [7:0] VEC_OVF = 8'h04;
   localparam logic [7:0] VEC_RANGE = 8'h05;
   localparam logic [7:0] VEC_FPU = 8'h10;
   localparam logic [7:0] VEC_SIMD = 8'h13;
   // Overflow bit position inside the flags word.
   localparam int FLAG_OVF_BIT = 11;
   // Stack slot sizes in bytes and table entry shifts per mode.
   localparam logic [3:0] SLOT_REAL = 4'h2;
   localparam logic [3:0] SLOT_LEGACY = 4'h4;
   localparam logic [3:0] SLOT_LONG = 4'h8;
   localparam logic [2:0] SHIFT_REAL = 3'h2;
   localparam logic [2:0] SHIFT_LEGACY = 3'h3;
   localparam logic [2:0] SHIFT_LONG = 3'h4;
   localparam logic [15:0] NULL_SEL = 16'h0000;
   // One-hot sequencer states.
   typedef enum logic [15:0] {
      ST_IDLE = 16'h0001, ST_FETCH = 16'h0002, ST_PUSH_SS = 16'h0004,
      ST_PUSH_SP = 16'h0008, ST_PUSH_FL = 16'h0010, ST_PUSH_CS = 16'h0020,
      ST_PUSH_IP = 16'h0040, ST_PUSH_ERR = 16'h0080, ST_POP_IP = 16'h0100,
      ST_POP_CS = 16'h0200, ST_POP_FL = 16'h0400, ST_POP_SP = 16'h0800,
      ST_POP_SS = 16'h1000, ST_LIM_LO = 16'h2000, ST_LIM_HI = 16'h4000,
      ST_FINISH = 16'h8000
   } edu_state_t;
endpackage : edu_pkg

// File: edu_cause_decode.sv
// Decodes an explicit trap request into a dispatch decision and vector.
`timescale 1ns/100ps
module edu_cause_decode (
   // Request description.
   input wire logic [2:0] kind,
   input wire logic [7:0] soft_vector,
   input wire logic overflow_flag,
   input wire logic [5:0] fp_conds,
   // Decision.
   output logic dispatch,
   output logic [7:0] vector
);
   // Chooses the vector; arithmetic overflow alone never reaches here.
   always_comb begin
      dispatch = 1'b0;
      vector = soft_vector;
      case (kind)
         edu_pkg::KIND_SOFT, edu_pkg::KIND_EXC: begin
            dispatch = 1'b1;
         end
         edu_pkg::KIND_OVF: begin
            dispatch = overflow_flag;
            vector = edu_pkg::VEC_OVF;
         end
         edu_pkg::KIND_BRK: begin
            dispatch = 1'b1;
            vector = edu_pkg::VEC_BRK;
         end
         edu_pkg::KIND_FPU: begin
            dispatch = |fp_conds;
            vector = edu_pkg::VEC_FPU;
         end
         edu_pkg::KIND_SIMD: begin
            dispatch = |fp_conds;
            vector = edu_pkg::VEC_SIMD;
         end
         default: begin
            dispatch = 1'b0;
         end
      endcase
   end
endmodule : edu_cause_decode

// File: edu_dispatch.sv
// Exception dispatch sequencer: vectoring, stack saves and trap return.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module edu_dispatch (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Register port.
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Request from the pipeline.
   input wire logic req_valid,
   input wire logic instr_boundary,
   input wire logic [2:0] req_kind,
   input wire logic [7:0] req_vector,
   input wire logic req_err_valid,
   input wire logic [31:0] req_err_code,
   input wire logic [1:0] req_target_privilege,
   input wire logic req_system_mgmt_irq,
   input wire logic [63:0] req_bound_addr,
   input wire logic [63:0] req_operand,
   input wire logic [5:0] req_fp_conds,
   output logic req_ready,
   // Architectural state at the request.
   input wire logic [31:0] flags_word,
   input wire logic [63:0] instr_pointer,
   input wire logic [15:0] code_sel,
   input wire logic [15:0] stack_sel,
   input wire logic [63:0] wide_stack_pointer,
   input wire logic [1:0] current_privilege,
   input wire logic [63:0] switch_stack_pointer,
   input wire logic [15:0] switch_stack_sel,
   // Memory port for table reads and stack traffic.
   output logic mem_req,
   output logic mem_we,
   output logic [63:0] mem_addr,
   output logic [63:0] mem_wdata,
   output logic [3:0] mem_size,
   input wire logic [63:0] mem_rdata,
   input wire logic mem_ack,
   // Result of a finished request.
   output logic done,
   output logic dispatched,
   output logic [7:0] handler_vector,
   output logic [63:0] out_ip,
   output logic [15:0] out_cs,
   output logic [31:0] out_flags,
   output logic [63:0] out_sp,
   output logic [15:0] out_ss,
   output logic handler_long_code
);
   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   edu_pkg::edu_state_t state;
   logic [2:0] ctrl;
   logic [63:0] table_base;
   logic [5:0] fp_sticky;
   logic [15:0] dispatch_count;
   logic [2:0] cap_kind;
   logic [7:0] cap_vec;
   logic cap_err;
   logic [31:0] cap_err_code;
   logic [1:0] cap_target;
   logic [1:0] cap_priv;
   logic cap_mgt;
   logic [63:0] cap_bound;
   logic [63:0] cap_operand;
   logic [31:0] saved_flags;
   logic [63:0] saved_ip;
   logic [15:0] saved_cs;
   logic [15:0] saved_ss;
   logic [63:0] saved_sp;
   logic [63:0] work_sp;
   logic [63:0] bound_lo;
   logic [1:0] mode;
   logic [3:0] slot;
   logic [2:0] shift;
   logic [63:0] val_mask;
   logic take;
   logic dec_dispatch;
   logic [7:0] dec_vector;
   logic priv_chg;
   logic is_push;
   logic is_pop;
   logic [63:0] push_val;
   logic [63:0] op_addr;
   logic [63:0] rd_sext;
   logic ret_priv_chg;

   // Sign-extends a stack-sized value to the full datapath width.
   function automatic logic [63:0] sext(input logic [63:0] v, input logic [3:0] s);
      logic [63:0] r;
      r = v;
      if (s == edu_pkg::SLOT_REAL) begin
         r = {{48{v[15]}}, v[15:0]};
      end else if (s == edu_pkg::SLOT_LEGACY) begin
         r = {{32{v[31]}}, v[31:0]};
      end
      return r;
   endfunction : sext

   // ---------------------------------------------------------------
   // Request decode
   // ---------------------------------------------------------------
   edu_cause_decode u_decode (
      .kind(req_kind),
      .soft_vector(req_vector),
      .overflow_flag(flags_word[edu_pkg::FLAG_OVF_BIT]),
      .fp_conds(req_fp_conds),
      .dispatch(dec_dispatch),
      .vector(dec_vector)
   );

   // A request is only taken between instructions.
   assign take = req_valid & req_ready & instr_boundary;
   assign mode = ctrl[1:0];
   assign priv_chg = (mode != edu_pkg::MODE_REAL) && (cap_target != cap_priv);
   assign ret_priv_chg = (mode == edu_pkg::MODE_LEGACY) && (out_cs[1:0] != cap_priv);
   assign is_push = (state == edu_pkg::ST_PUSH_SS) || (state == edu_pkg::ST_PUSH_SP) ||
                    (state == edu_pkg::ST_PUSH_FL) || (state == edu_pkg::ST_PUSH_CS) ||
                    (state == edu_pkg::ST_PUSH_IP) || (state == edu_pkg::ST_PUSH_ERR);
   assign is_pop = (state == edu_pkg::ST_POP_IP) || (state == edu_pkg::ST_POP_CS) ||
                   (state == edu_pkg::ST_POP_FL) || (state == edu_pkg::ST_POP_SP) ||
                   (state == edu_pkg::ST_POP_SS);
   assign rd_sext = sext(mem_rdata, slot);

   // Slot size, table stride and zero-extension mask follow the mode.
   always_comb begin
      case (mode)
         edu_pkg::MODE_REAL: begin
            slot = edu_pkg::SLOT_REAL;
            shift = edu_pkg::SHIFT_REAL;
            val_mask = {48'h0, 16'hFFFF};
         end
         edu_pkg::MODE_LEGACY: begin
            slot = edu_pkg::SLOT_LEGACY;
            shift = edu_pkg::SHIFT_LEGACY;
            val_mask = {32'h0, 32'hFFFFFFFF};
         end
         default: begin
            slot = edu_pkg::SLOT_LONG;
            shift = edu_pkg::SHIFT_LONG;
            val_mask = {64{1'b1}};
         end
      endcase
   end

   // Value and address of the memory access for the current state.
   always_comb begin
      case (state)
         edu_pkg::ST_PUSH_SS: push_val = {48'h0, saved_ss};
         edu_pkg::ST_PUSH_SP: push_val = saved_sp;
         edu_pkg::ST_PUSH_FL: push_val = {32'h0, saved_flags};
         edu_pkg::ST_PUSH_CS: push_val = {48'h0, saved_cs};
         edu_pkg::ST_PUSH_IP: push_val = saved_ip;
         edu_pkg::ST_PUSH_ERR: push_val = {32'h0, cap_err_code};
         default: push_val = 64'h0;
      endcase
      case (state)
         edu_pkg::ST_FETCH: op_addr = table_base + ({56'h0, cap_vec} << shift);
         edu_pkg::ST_LIM_LO: op_addr = cap_bound;
         edu_pkg::ST_LIM_HI: op_addr = cap_bound + {60'h0, slot};
         default: op_addr = is_push ? (work_sp - {60'h0, slot}) : work_sp;
      endcase
   end

   // ---------------------------------------------------------------
   // Register port
   // ---------------------------------------------------------------
   // Control and table base writes; read data stands one cycle.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= edu_pkg::CTRL_RST;
         table_base <= 64'h0;
      end else if (reg_wr) begin
         if (reg_addr == edu_pkg::REG_CTRL) begin
            ctrl <= reg_wdata[2:0];
         end
         if (reg_addr == edu_pkg::REG_BASE) begin
            table_base <= {32'h0, reg_wdata};
         end
      end
   end

   // Read mux; unmapped addresses read as zero.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            edu_pkg::REG_CTRL: reg_rdata <= {29'h0, ctrl};
            edu_pkg::REG_BASE: reg_rdata <= table_base[31:0];
            edu_pkg::REG_STAT: reg_rdata <= {dispatch_count, 6'h0, dispatched,
                                             state != edu_pkg::ST_IDLE, handler_vector};
            edu_pkg::REG_FPC: reg_rdata <= {26'h0, fp_sticky};
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // Sticky record of the six float conditions; a new set beats a clear.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fp_sticky <= 6'h00;
      end else begin
         fp_sticky <= (fp_sticky & ~((reg_wr && reg_addr == edu_pkg::REG_FPC) ?
                       reg_wdata[5:0] : 6'h00)) |
                      ((take && (req_kind == edu_pkg::KIND_FPU ||
                        req_kind == edu_pkg::KIND_SIMD)) ? req_fp_conds : 6'h00);
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Captures a request, walks the table read and stack traffic, reports.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= edu_pkg::ST_IDLE;
         req_ready <= 1'b0;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 64'h0;
         mem_wdata <= 64'h0;
         mem_size <= 4'h0;
         done <= 1'b0;
         dispatched <= 1'b0;
         handler_vector <= 8'h00;
         out_ip <= 64'h0;
         out_cs <= 16'h0;
         out_flags <= 32'h0;
         out_sp <= 64'h0;
         out_ss <= 16'h0;
         handler_long_code <= 1'b0;
         dispatch_count <= 16'h0;
         cap_kind <= 3'h0;
         cap_vec <= 8'h00;
         cap_err <= 1'b0;
         cap_err_code <= 32'h0;
         cap_target <= 2'h0;
         cap_priv <= 2'h0;
         cap_mgt <= 1'b0;
         cap_bound <= 64'h0;
         cap_operand <= 64'h0;
         saved_flags <= 32'h0;
         saved_ip <= 64'h0;
         saved_cs <= 16'h0;
         saved_ss <= 16'h0;
         saved_sp <= 64'h0;
         work_sp <= 64'h0;
         bound_lo <= 64'h0;
      end else begin
         done <= 1'b0;
         if (state == edu_pkg::ST_IDLE) begin
            req_ready <= ctrl[edu_pkg::CTRL_EN_BIT] & ~take;
            if (take) begin
               cap_kind <= req_kind;
               cap_vec <= dec_vector;
               cap_err <= req_err_valid && (req_kind == edu_pkg::KIND_EXC);
               cap_err_code <= req_err_code;
               cap_target <= req_target_privilege;
               cap_priv <= current_privilege;
               cap_mgt <= req_system_mgmt_irq;
               cap_bound <= req_bound_addr;
               cap_operand <= req_operand;
               saved_flags <= flags_word;
               saved_ip <= instr_pointer;
               saved_cs <= code_sel;
               saved_ss <= stack_sel;
               saved_sp <= wide_stack_pointer;
               work_sp <= wide_stack_pointer;
               out_ss <= stack_sel;
               if (req_kind == edu_pkg::KIND_RET) begin
                  state <= edu_pkg::ST_POP_IP;
               end else if (req_kind == edu_pkg::KIND_LIMIT) begin
                  state <= edu_pkg::ST_LIM_LO;
               end else if (dec_dispatch) begin
                  state <= edu_pkg::ST_FETCH;
               end else begin
                  state <= edu_pkg::ST_FINISH;
               end
            end
         end else if (state == edu_pkg::ST_FINISH) begin
            done <= 1'b1;
            req_ready <= ctrl[edu_pkg::CTRL_EN_BIT];
            out_sp <= work_sp;
            state <= edu_pkg::ST_IDLE;
         end else if (!mem_req) begin
            // Issue the access of this state; pushes predecrement the pointer.
            mem_req <= 1'b1;
            mem_we <= is_push;
            mem_addr <= op_addr;
            mem_wdata <= push_val & val_mask;
            mem_size <= (state == edu_pkg::ST_FETCH) ? edu_pkg::SLOT_LONG : slot;
            if (is_push) begin
               work_sp <= op_addr;
            end
         end else if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            if (is_pop) begin
               work_sp <= work_sp + {60'h0, slot};
            end
            case (state)
               edu_pkg::ST_FETCH: begin
                  dispatched <= 1'b1;
                  handler_vector <= cap_vec;
                  dispatch_count <= dispatch_count + 16'h1;
                  out_flags <= saved_flags;
                  handler_long_code <= (mode == edu_pkg::MODE_LONG) && !cap_mgt;
                  if (mode == edu_pkg::MODE_REAL) begin
                     out_ip <= {48'h0, mem_rdata[15:0]};
                     out_cs <= mem_rdata[31:16];
                     state <= edu_pkg::ST_PUSH_FL;
                  end else begin
                     out_ip <= {16'h0, mem_rdata[47:0]};
                     out_cs <= mem_rdata[63:48];
                     if (priv_chg) begin
                        work_sp <= switch_stack_pointer;
                        out_ss <= (mode == edu_pkg::MODE_LONG) ?
                                  edu_pkg::NULL_SEL : switch_stack_sel;
                     end
                     if (mode == edu_pkg::MODE_LONG || priv_chg) begin
                        state <= edu_pkg::ST_PUSH_SS;
                     end else begin
                        state <= edu_pkg::ST_PUSH_FL;
                     end
                  end
               end
               edu_pkg::ST_PUSH_SS: state <= edu_pkg::ST_PUSH_SP;
               edu_pkg::ST_PUSH_SP: state <= edu_pkg::ST_PUSH_FL;
               edu_pkg::ST_PUSH_FL: state <= edu_pkg::ST_PUSH_CS;
               edu_pkg::ST_PUSH_CS: state <= edu_pkg::ST_PUSH_IP;
               edu_pkg::ST_PUSH_IP: begin
                  state <= cap_err ? edu_pkg::ST_PUSH_ERR : edu_pkg::ST_FINISH;
               end
               edu_pkg::ST_PUSH_ERR: state <= edu_pkg::ST_FINISH;
               edu_pkg::ST_POP_IP: begin
                  dispatched <= 1'b0;
                  out_ip <= mem_rdata & val_mask;
                  state <= edu_pkg::ST_POP_CS;
               end
               edu_pkg::ST_POP_CS: begin
                  out_cs <= mem_rdata[15:0];
                  state <= edu_pkg::ST_POP_FL;
               end
               edu_pkg::ST_POP_FL: begin
                  out_flags <= mem_rdata[31:0];
                  if (mode == edu_pkg::MODE_LONG || ret_priv_chg) begin
                     state <= edu_pkg::ST_POP_SP;
                  end else begin
                     state <= edu_pkg::ST_FINISH;
                  end
               end
               edu_pkg::ST_POP_SP: begin
                  saved_sp <= mem_rdata & val_mask;
                  state <= edu_pkg::ST_POP_SS;
               end
               edu_pkg::ST_POP_SS: begin
                  out_ss <= mem_rdata[15:0];
                  work_sp <= saved_sp;
                  state <= edu_pkg::ST_FINISH;
               end
               edu_pkg::ST_LIM_LO: begin
                  bound_lo <= rd_sext;
                  state <= edu_pkg::ST_LIM_HI;
               end
               edu_pkg::ST_LIM_HI: begin
                  if ($signed(sext(cap_operand, slot)) < $signed(bound_lo) ||
                      $signed(sext(cap_operand, slot)) > $signed(rd_sext)) begin
                     cap_vec <= edu_pkg::VEC_RANGE;
                     state <= edu_pkg::ST_FETCH;
                  end else begin
                     dispatched <= 1'b0;
                     state <= edu_pkg::ST_FINISH;
                  end
               end
               default: state <= edu_pkg::ST_IDLE;
            endcase
         end
         if (take && !dec_dispatch && req_kind != edu_pkg::KIND_RET &&
             req_kind != edu_pkg::KIND_LIMIT) begin
            dispatched <= 1'b0;
         end
      end
   end
endmodule : edu_dispatch

// File: edu_mem_model.sv
// Memory partner that answers the dispatch unit's table and stack accesses.
`timescale 1ns/100ps
module edu_mem_model (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Memory port.
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [63:0] mem_addr,
   input wire logic [63:0] mem_wdata,
   input wire logic [3:0] mem_size,
   input wire logic [3:0] lat,
   output logic [63:0] mem_rdata,
   output logic mem_ack
);
   logic [3:0] cnt;
   logic [63:0] wa[$], wd[$];
   logic [3:0] ws[$];
   // Acks after lat cycles; data follows the address, else toggles.
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= 4'h0;
         mem_ack <= 1'b0;
         mem_rdata <= 64'h0;
      end else if (mem_req && !mem_ack && cnt == lat) begin
         cnt <= 4'h0;
         mem_ack <= 1'b1;
         mem_rdata <= {~mem_addr[31:0], mem_addr[31:0]};
         if (mem_we) begin
            wa.push_back(mem_addr);
            wd.push_back(mem_wdata);
            ws.push_back(mem_size);
         end
      end else begin
         cnt <= (mem_req && !mem_ack) ? cnt + 4'h1 : 4'h0;
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : edu_mem_model

// File: edu_dispatch_asserts.sv
// Concurrent checks on the request, memory and result ports of the dispatcher.
`timescale 1ns/100ps
module edu_dispatch_asserts (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Request side.
   input wire logic req_valid,
   input wire logic instr_boundary,
   input wire logic [2:0] req_kind,
   input wire logic [31:0] flags_word,
   input wire logic [5:0] req_fp_conds,
   input wire logic req_ready,
   // Memory side.
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [63:0] mem_addr,
   input wire logic [63:0] mem_wdata,
   input wire logic [3:0] mem_size,
   input wire logic mem_ack,
   // Results.
   input wire logic done,
   input wire logic dispatched,
   input wire logic [7:0] handler_vector
);
   logic take, ovf_q, fp_q;
   logic [2:0] k_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Mirrors the take condition.
   assign take = req_valid && req_ready && instr_boundary;
   // Keeps the kind and deciding inputs of the request in flight.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         k_q <= 3'h0;
         ovf_q <= 1'b0;
         fp_q <= 1'b0;
      end else if (take) begin
         k_q <= req_kind;
         ovf_q <= flags_word[edu_pkg::FLAG_OVF_BIT];
         fp_q <= |req_fp_conds;
      end
   end
   AST_TAKE_READY: assert property (take |=> !req_ready)
      else $error("ready after take");
   AST_OFF_BOUNDARY: assert property (req_ready && req_valid && !instr_boundary |=> req_ready)
      else $error("taken off boundary");
   AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
      else $error("request changed");
   AST_ZERO_EXT: assert property (mem_req && mem_we && mem_size != 4'h8 |-> (mem_wdata >> {mem_size, 3'h0}) == 64'h0)
      else $error("not zero extended");
   AST_DONE_BOUND: assert property (take |-> ##[2:300] done)
      else $error("never done");
   AST_BRK: assert property (done && k_q == edu_pkg::KIND_BRK |-> dispatched && handler_vector == edu_pkg::VEC_BRK)
      else $error("bad breakpoint");
   AST_OVF: assert property (done && k_q == edu_pkg::KIND_OVF |-> dispatched == ovf_q && (!ovf_q || handler_vector == edu_pkg::VEC_OVF))
      else $error("bad overflow call");
   AST_FP: assert property (done && fp_q && (k_q == edu_pkg::KIND_FPU || k_q == edu_pkg::KIND_SIMD) |-> handler_vector == ((k_q == edu_pkg::KIND_SIMD) ? edu_pkg::VEC_SIMD : edu_pkg::VEC_FPU))
      else $error("bad float vector");
endmodule : edu_dispatch_asserts
bind edu_dispatch edu_dispatch_asserts edu_dispatch_asserts_i (.*);

// File: tb_exception_dispatch_unit.sv
// Self-checking bench for the exception dispatch sequencer.
`timescale 1ns/100ps
module tb_exception_dispatch_unit;
   logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
   logic instr_boundary = 1'b1, req_err_valid = 1'b0, req_system_mgmt_irq = 1'b0;
   logic [3:0] reg_addr = 4'h0, lat = 4'h2;
   logic [31:0] reg_wdata = 32'h0, req_err_code = 32'h0, flags_word = 32'h202;
   logic [2:0] req_kind = 3'h0;
   logic [7:0] req_vector = 8'h0;
   logic [1:0] req_target_privilege = 2'h0, current_privilege = 2'h0;
   logic [63:0] req_bound_addr = 64'h1000, req_operand = 64'h0, instr_pointer = 64'h5678;
   logic [63:0] wide_stack_pointer = 64'h800, switch_stack_pointer = 64'h4000;
   logic [15:0] code_sel = 16'h1234, stack_sel = 16'h2B, switch_stack_sel = 16'h10;
   logic [5:0] req_fp_conds = 6'h0;
   logic [31:0] reg_rdata, out_flags;
   logic req_ready, mem_req, mem_we, mem_ack, done, dispatched, handler_long_code;
   logic [63:0] mem_addr, mem_wdata, mem_rdata, out_ip, out_sp;
   logic [3:0] mem_size;
   logic [7:0] handler_vector;
   logic [15:0] out_cs, out_ss;
   int miscompares = 0, n_compared = 0;
   edu_dispatch edu_dispatch_i (.*);
   edu_mem_model edu_mem_model_i (.*);
   // Core clock.
   always #12.5 ref_clk = ~ref_clk;
   task chk(input logic [63:0] s, input logic [63:0] e);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value at %0t: %h, expected %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task rd(input logic [3:0] a, input logic [31:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      chk(reg_rdata, e);
   endtask : rd
   task go(input logic [2:0] k, input logic [7:0] v);
      int i;
      edu_mem_model_i.wa.delete();
      edu_mem_model_i.wd.delete();
      edu_mem_model_i.ws.delete();
      req_kind <= k;
      req_vector <= v;
      req_valid <= 1'b1;
      instr_boundary <= 1'b1;
      i = 0;
      do @(posedge ref_clk); while (req_ready !== 1'b1 && ++i < 50);
      req_valid <= 1'b0;
      do @(posedge ref_clk); while (done !== 1'b1 && ++i < 300);
      chk(done, 1'b1);
   endtask : go
   task pushes(input logic [63:0] sp, input int n, input logic [3:0] sz);
      chk(edu_mem_model_i.wa.size(), n);
      for (int i = 0; i < n; i++) begin
         chk(edu_mem_model_i.wa[i], sp - sz * (i + 1));
         chk(edu_mem_model_i.ws[i], sz);
      end
   endtask : pushes
   task t_brk;
      instr_boundary <= 1'b0;
      req_valid <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(req_ready, 1'b1);
      go(edu_pkg::KIND_BRK, 8'h00);
      chk(handler_vector, edu_pkg::VEC_BRK);
      chk(out_ip, 64'h010C);
      chk(out_cs, 16'h0001);
      pushes(64'h800, 3, 4'h2);
      chk(edu_mem_model_i.wd[2], 64'h5678);
      chk(out_sp, 64'h7FA);
      rd(edu_pkg::REG_STAT, 32'h10203);
   endtask : t_brk
   task t_ovf;
      lat <= 4'h0;
      go(edu_pkg::KIND_OVF, 8'h00);
      chk(dispatched, 1'b0);
      go(edu_pkg::KIND_SOFT, edu_pkg::VEC_OVF);
      chk(handler_vector, edu_pkg::VEC_OVF);
      go(edu_pkg::KIND_SOFT, 8'h21);
      chk(out_ip, 64'h0184);
      flags_word <= 32'hA02;
      go(edu_pkg::KIND_OVF, 8'h00);
      chk(handler_vector, edu_pkg::VEC_OVF);
      chk(edu_mem_model_i.wd[0], 64'hA02);
   endtask : t_ovf
   task t_limit;
      lat <= 4'h3;
      req_operand <= 64'h1002;
      go(edu_pkg::KIND_LIMIT, 8'h00);
      chk(dispatched, 1'b0);
      req_operand <= 64'h1003;
      go(edu_pkg::KIND_LIMIT, 8'h00);
      chk(handler_vector, edu_pkg::VEC_RANGE);
      chk(edu_mem_model_i.wa.size(), 3);
   endtask : t_limit
   task t_fp;
      for (int i = 0; i < 6; i++) begin
         req_fp_conds <= 6'h01 << i;
         go(edu_pkg::KIND_FPU, 8'h00);
         chk(handler_vector, edu_pkg::VEC_FPU);
      end
      req_fp_conds <= 6'h21;
      go(edu_pkg::KIND_SIMD, 8'h00);
      chk(handler_vector, edu_pkg::VEC_SIMD);
      req_fp_conds <= 6'h0;
      go(edu_pkg::KIND_FPU, 8'h00);
      chk(dispatched, 1'b0);
      rd(edu_pkg::REG_FPC, 32'h3F);
      wr(edu_pkg::REG_FPC, 32'h3F);
      rd(edu_pkg::REG_FPC, 32'h0);
   endtask : t_fp
   task t_ret;
      go(edu_pkg::KIND_RET, 8'h00);
      chk(out_ip, 64'h0800);
      chk(out_cs, 16'h0802);
      chk(out_flags, 32'h0804);
   endtask : t_ret
   task t_wide;
      wr(edu_pkg::REG_CTRL, 32'h6);
      current_privilege <= 2'h3;
      req_err_valid <= 1'b1;
      req_err_code <= 32'hDEAD;
      go(edu_pkg::KIND_EXC, 8'h0E);
      chk(handler_long_code, 1'b1);
      chk(out_ss, edu_pkg::NULL_SEL);
      chk(out_ip, 64'hFE1F_0001_01E0);
      pushes(64'h4000, 6, 4'h8);
      chk(edu_mem_model_i.wd[0], 64'h2B);
      chk(edu_mem_model_i.wd[5], 64'hDEAD);
      current_privilege <= 2'h0;
      req_err_valid <= 1'b0;
      req_system_mgmt_irq <= 1'b1;
      go(edu_pkg::KIND_SOFT, 8'h20);
      chk(handler_long_code, 1'b0);
      pushes(64'h800, 5, 4'h8);
      wr(edu_pkg::REG_CTRL, 32'h5);
      go(edu_pkg::KIND_SOFT, 8'h20);
      pushes(64'h800, 3, 4'h4);
   endtask : t_wide
   task summarize;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // Reset, then every scenario.
   initial begin
      repeat (3) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd(edu_pkg::REG_CTRL, 32'h4);
      wr(edu_pkg::REG_BASE, 32'h0001_0100);
      rd(edu_pkg::REG_BASE, 32'h0001_0100);
      rd(4'h2, 32'h0);
      t_brk;
      t_ovf;
      t_limit;
      t_fp;
      t_ret;
      t_wide;
      summarize;
   end
   // Ends a hung run.
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      summarize;
   end
endmodule : tb_exception_dispatch_unit
